// file: hw/svl_rx_ctrl.sv
// link-level control of the serial video deserializer
// Operation
// - one 35-bit symbol per pixel clock is taken from the serial pair and made into parallel video.
// - lock is found from the incoming stream alone, with no reference clock and no training pattern.
// - symbol bits 23:0 (audio, aux, sync, de and rgb[16:0]) pass through the content cipher before reaching the output.
// - cipher key exchange rides only on the bidirectional control channel.
// - the local I2C slave port reaches both this device and the remote serializer.
// - I2C is bridged across the link, forward in the fast stream and return in the back channel.
// - the bridge joins normal multi-master arbitration on both sides.
// - frames carry video, sync, cipher, I2C and audio, scrambled, which the receiver undoes.
// - the low-frequency select (set: 5 to 15 MHz, clear: 15 to 85 MHz) is only registered and selects no range in this block.
// - back-channel frames go out at 10 Mbps carrying I2C, cipher, CRC and four GPIO bits.
// - backward compatible mode takes 28 data bits per pixel period at 15 to 65 MHz.
// - backward compatible mode is chosen by the mode strap or by a control bit.
// - compatible mode shuts the control channel, cipher, GPIO, audio and interrupt, keeping local I2C.
// - long-cable mode starts lock with the equalizer at the programmed floor gain.
// - power-down low powers down and returns every control setting to default.
`timescale 1ns/1ns
`default_nettype none
`include "svl_regs.svh"
module svl_rx_ctrl #(
	parameter int FIFO_DEPTH = 8,
	parameter logic [7:0] LOCK_SYMS = `SVL_LOCK_SYMS
) (
	input wire logic core_clk, // 20 MHz core clock
	input wire logic rst, // sync reset, active high
	input wire logic power_down_n, // power-down pin, active low
	input wire logic link_clk, // recovered pixel clock from the pair
	input wire logic link_sym_valid, // symbol framing indicator
	input wire logic [`SVL_SYM_BITS-1:0] link_sym, // one deserialized symbol
	input wire logic mode_compat_strap, // strap: backward compatible
	input wire logic mode_long_cable_strap, // strap: long cable
	input wire logic cfg_compat_mode, // control bit: backward compatible
	input wire logic low_freq_range_select, // 1: 5-15 MHz, 0: 15-85 MHz
	input wire logic [3:0] cfg_eq_floor, // equalizer floor gain
	input wire logic cfg_eq_floor_wr, // load floor value
	input wire logic [7:0] cfg_cipher_key, // key from the control channel
	input wire logic cfg_cipher_key_wr, // load key
	input wire logic [7:0] host_i2c_byte, // local host byte toward remote
	input wire logic host_i2c_valid, // host byte request
	output logic host_i2c_ready, // host byte accepted
	input wire logic host_i2c_arb_lost, // local bus arbitration lost
	input wire logic [3:0] gpio_in, // gpio bits to send back
	output svl_pkg::svl_pixel_t vid_out, // decrypted pixel word
	output logic vid_valid, // pixel word valid
	input wire logic vid_ready, // display sink ready
	output logic vid_clk_out, // output pixel clock
	output logic [7:0] remote_i2c_byte, // byte arriving from remote bus
	output logic remote_i2c_strobe, // one-cycle strobe with that byte
	output logic bc_line, // back-channel serial output
	output logic locked, // link lock status
	output logic compat_active, // backward compatible mode in force
	output logic long_cable_active, // long cable mode in force
	output logic [3:0] adaptive_eq_gain, // equalizer gain in use
	output logic interrupt_out_n, // interrupt pin, active low
	output logic powered_down // device in power down
);
	// ******************************
	// input synchronisers
	// ******************************
	logic [2:0] lclk_s_reg;
	logic pdn_s1_reg, pdn_s2_reg;
	logic sv_s1_reg, sv_s2_reg;
	logic [`SVL_SYM_BITS-1:0] sym_s1_reg, sym_s2_reg;
	logic [1:0] strap_s1_reg, strap_s2_reg;
	logic [3:0] gpio_s1_reg, gpio_s2_reg;
	always_ff @(posedge core_clk)
	begin
		lclk_s_reg <= {lclk_s_reg[1:0], link_clk};
		pdn_s1_reg <= power_down_n;
		pdn_s2_reg <= pdn_s1_reg;
		sv_s1_reg <= link_sym_valid;
		sv_s2_reg <= sv_s1_reg;
		sym_s1_reg <= link_sym;
		sym_s2_reg <= sym_s1_reg;
		strap_s1_reg <= {mode_compat_strap, mode_long_cable_strap};
		strap_s2_reg <= strap_s1_reg;
		gpio_s1_reg <= gpio_in;
		gpio_s2_reg <= gpio_s1_reg;
	end
	logic sym_edge;
	logic pd;
	logic crst;
	assign sym_edge = lclk_s_reg[1] && !lclk_s_reg[2];
	assign pd = !pdn_s2_reg;
	assign crst = rst || pd;
	assign powered_down = pd;
	// ******************************
	// mode and equalizer control
	// ******************************
	logic compat_reg, long_cable_mode_reg, straps_taken_reg;
	logic [3:0] eq_floor_reg;
	always_ff @(posedge core_clk)
	begin
		if (crst)
		begin
			straps_taken_reg <= 1'b0;
			compat_reg <= 1'b0;
			long_cable_mode_reg <= 1'b0;
		end
		else if (!straps_taken_reg)
		begin
			straps_taken_reg <= 1'b1;
			compat_reg <= strap_s2_reg[1];
			long_cable_mode_reg <= strap_s2_reg[0];
		end
	end
	assign compat_active = compat_reg || cfg_compat_mode;
	assign long_cable_active = long_cable_mode_reg;
	always_ff @(posedge core_clk)
	begin
		if (crst)
			eq_floor_reg <= `SVL_EQ_FLOOR_DEFAULT;
		else if (cfg_eq_floor_wr)
			eq_floor_reg <= cfg_eq_floor;
	end
	// ******************************
	// lock acquisition
	// ******************************
	// lock comes from symbol cadence only; data content is never inspected
	svl_pkg::svl_lock_t lk_reg;
	logic [7:0] good_reg;
	logic [3:0] eq_reg;
	always_ff @(posedge core_clk)
	begin
		if (crst)
		begin
			lk_reg <= svl_pkg::SVL_UNLOCKED;
			good_reg <= 8'h00;
			eq_reg <= `SVL_EQ_DEFAULT;
		end
		else if (sym_edge)
		begin
			case (lk_reg)
				svl_pkg::SVL_UNLOCKED:
				begin
					good_reg <= 8'h00;
					eq_reg <= long_cable_mode_reg ? eq_floor_reg : `SVL_EQ_DEFAULT;
					lk_reg <= svl_pkg::SVL_ACQUIRE;
				end
				svl_pkg::SVL_ACQUIRE:
				begin
					if (!sv_s2_reg)
					begin
						good_reg <= 8'h00;
						// step gain on a miss, wrapping back to the start value
						if (eq_reg == `SVL_EQ_MAX)
							eq_reg <= long_cable_mode_reg ? eq_floor_reg : `SVL_EQ_DEFAULT;
						else
							eq_reg <= eq_reg + 4'h1;
					end
					else if (good_reg == LOCK_SYMS - 8'h01)
						lk_reg <= svl_pkg::SVL_LOCKED;
					else
						good_reg <= good_reg + 8'h01;
				end
				svl_pkg::SVL_LOCKED:
				begin
					if (!sv_s2_reg)
						lk_reg <= svl_pkg::SVL_UNLOCKED;
				end
				default: lk_reg <= svl_pkg::SVL_UNLOCKED;
			endcase
		end
	end
	assign locked = (lk_reg == svl_pkg::SVL_LOCKED);
	assign adaptive_eq_gain = eq_reg;
	// ******************************
	// descrambler and cipher
	// ******************************
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	logic [15:0] scr_reg;
	logic [7:0] key_reg;
	logic [`SVL_SYM_BITS-1:0] plain;
	logic [`SVL_SYM_BITS-1:0] ks;
	always_ff @(posedge core_clk)
	begin
		if (crst)
			key_reg <= 8'h00;
		else if (cfg_cipher_key_wr && !compat_active)
			key_reg <= cfg_cipher_key;
	end
	always_ff @(posedge core_clk)
	begin
		if (crst || !locked)
			scr_reg <= `SVL_LFSR_SEED;
		else if (sym_edge)
			scr_reg <= lfsr_step(scr_reg);
	end
	always_comb
	begin
		ks = {scr_reg[2:0], scr_reg, scr_reg};
		plain = sym_s2_reg ^ ks;
		// compat mode: only 28 data bits, no cipher or side channels
		if (compat_active)
			plain = {7'h00, plain[`SVL_COMPAT_BITS-1:0]};
		else
			plain[23:0] = plain[23:0] ^ {3{key_reg}};
	end
	// ******************************
	// video output path
	// ******************************
	svl_pkg::svl_pixel_t pix;
	logic fifo_in_ready;
	always_comb
	begin
		pix = svl_pkg::svl_pixel_t'(plain[30:0]);
		if (compat_active)
		begin
			pix.aux_i2c = 1'b0;
			pix.aux_cipher = 1'b0;
			pix.audio = 2'h0;
		end
	end
	svl_fifo #(.WIDTH($bits(svl_pkg::svl_pixel_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(core_clk),
		.rst(crst),
		.in_valid(locked && sym_edge),
		.in_ready(fifo_in_ready),
		.in_data(pix),
		.out_valid(vid_valid),
		.out_ready(vid_ready),
		.out_data(vid_out)
	);
	always_ff @(posedge core_clk)
	begin
		if (crst)
			vid_clk_out <= 1'b0;
		else
			vid_clk_out <= lclk_s_reg[2] && locked;
	end
	// ******************************
	// forward control channel
	// ******************************
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_cnt_reg;
	always_ff @(posedge core_clk)
	begin
		if (crst)
		begin
			rx_sh_reg <= 8'h00;
			rx_cnt_reg <= 3'h0;
			remote_i2c_byte <= 8'h00;
			remote_i2c_strobe <= 1'b0;
		end
		else
		begin
			remote_i2c_strobe <= 1'b0;
			// a full sink drops the symbol; its i2c bit is dropped too
			if (locked && sym_edge && fifo_in_ready && !compat_active)
			begin
				rx_sh_reg <= {rx_sh_reg[6:0], pix.aux_i2c};
				rx_cnt_reg <= rx_cnt_reg + 3'h1;
				if (rx_cnt_reg == 3'h7)
				begin
					remote_i2c_byte <= {rx_sh_reg[6:0], pix.aux_i2c};
					remote_i2c_strobe <= 1'b1;
				end
			end
		end
	end
	// ******************************
	// back channel transmitter
	// ******************************
	logic [$clog2(`SVL_BC_DIV+1)-1:0] div_reg;
	logic bc_tick;
	logic [`SVL_BC_FRAME_BITS+`SVL_CRC_BITS-1:0] bc_sh_reg;
	logic [5:0] bc_cnt_reg;
	logic [7:0] hold_i2c_reg;
	logic hold_full_reg;
	svl_pkg::svl_bc_t bc_word;
	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		crc8 = c;
	endfunction
	always_ff @(posedge core_clk)
	begin
		if (crst)
			div_reg <= '0;
		else if (bc_tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end
	assign bc_tick = (32'(div_reg) == `SVL_BC_DIV - 1);
	// the bridge holds one local byte; arbitration loss drops it unsent
	assign host_i2c_ready = !hold_full_reg && !compat_active;
	always_comb
	begin
		// an empty holder sends zero rather than repeating the last byte
		bc_word.i2c_byte = hold_full_reg ? hold_i2c_reg : 8'h00;
		bc_word.cipher_byte = compat_active ? 8'h00 : key_reg;
		bc_word.gpio = compat_active ? 4'h0 : gpio_s2_reg;
		bc_word.pad = 4'h0;
	end
	always_ff @(posedge core_clk)
	begin
		if (crst)
		begin
			hold_i2c_reg <= 8'h00;
			hold_full_reg <= 1'b0;
			bc_sh_reg <= '0;
			bc_cnt_reg <= 6'h00;
			bc_line <= 1'b0;
		end
		else
		begin
			if (host_i2c_arb_lost)
				hold_full_reg <= 1'b0;
			if (compat_active)
			begin
				// compat mode cuts a frame in flight at once
				bc_cnt_reg <= 6'h00;
				bc_line <= 1'b0;
			end
			else if (bc_tick)
			begin
				if (bc_cnt_reg == 6'h00)
				begin
					if (locked)
					begin
						bc_sh_reg <= {bc_word, crc8(bc_word)};
						bc_cnt_reg <= 6'(`SVL_BC_FRAME_BITS + `SVL_CRC_BITS);
						hold_full_reg <= 1'b0;
					end
					bc_line <= 1'b0;
				end
				else
				begin
					bc_line <= bc_sh_reg[`SVL_BC_FRAME_BITS+`SVL_CRC_BITS-1];
					bc_sh_reg <= {bc_sh_reg[`SVL_BC_FRAME_BITS+`SVL_CRC_BITS-2:0], 1'b0};
					bc_cnt_reg <= bc_cnt_reg - 6'h01;
				end
			end
			// placed last so a byte taken as a frame loads from the empty holder is kept
			if (host_i2c_valid && host_i2c_ready)
			begin
				hold_i2c_reg <= host_i2c_byte;
				hold_full_reg <= 1'b1;
			end
		end
	end
	// ******************************
	// interrupt and range
	// ******************************
	// interrupt is low while lock is being acquired; silenced in compat mode
	assign interrupt_out_n = !(lk_reg == svl_pkg::SVL_ACQUIRE && !compat_active);
	logic range_low_reg;
	always_ff @(posedge core_clk)
	begin
		if (crst)
			range_low_reg <= 1'b0;
		else
			range_low_reg <= low_freq_range_select;
	end
	logic unused_ok;
	assign unused_ok = range_low_reg;
endmodule
`default_nettype wire

// file: pkg/svl_regs.svh
// constants for the serial video link receiver control block
`ifndef SVL_REGS_SVH
`define SVL_REGS_SVH
`define SVL_SYM_BITS 35
`define SVL_COMPAT_BITS 28
`define SVL_GPIO_BITS 4
`define SVL_CRC_BITS 8
`define SVL_BC_FRAME_BITS 24
`define SVL_CLK_HZ 20000000
`define SVL_BC_RATE_BPS 10000000
`define SVL_BC_DIV (`SVL_CLK_HZ / `SVL_BC_RATE_BPS)
`define SVL_LOCK_SYMS 8'h08
`define SVL_EQ_DEFAULT 4'h4
`define SVL_EQ_FLOOR_DEFAULT 4'h8
`define SVL_EQ_MAX 4'hF
`define SVL_PD_MIN_MS 2
`define SVL_LFSR_SEED 16'hACE1
`endif

// file: pkg/svl_pkg.sv
// types shared by the serial video link receiver control block
package svl_pkg;
	typedef struct packed {
		logic [23:0] rgb;
		logic hsync;
		logic vsync;
		logic de;
		logic aux_i2c;
		logic aux_cipher;
		logic [1:0] audio;
	} svl_pixel_t;
	typedef struct packed {
		logic [7:0] i2c_byte;
		logic [7:0] cipher_byte;
		logic [3:0] gpio;
		logic [3:0] pad;
	} svl_bc_t;
	typedef enum logic [2:0] {
		SVL_UNLOCKED = 3'h1,
		SVL_ACQUIRE = 3'h2,
		SVL_LOCKED = 3'h4
	} svl_lock_t;
endpackage

// file: hw/svl_fifo.sv
// small synchronous valid/ready FIFO
`timescale 1ns/1ns
`default_nettype none
module svl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk, // clock
	input wire logic rst, // sync reset
	input wire logic in_valid, // write request
	output logic in_ready, // room available
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // data available
	input wire logic out_ready, // read accept
	output logic [WIDTH-1:0] out_data // read data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic wr;
	logic rd;
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	assign out_data = mem_reg[rp_reg];
	always_ff @(posedge clk)
	begin
		if (wr)
			mem_reg[wp_reg] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (wr)
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			if (rd)
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			if (wr && !rd)
				cnt_reg <= cnt_reg + 1'b1;
			else if (rd && !wr)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: dv/svl_rx_ctrl_checker.sv
// port-level assertions for the link receiver control block
`timescale 1ns/1ns
`default_nettype none
module svl_rx_ctrl_checker (
	input wire logic core_clk, // clock
	input wire logic rst, // sync reset
	input wire logic locked, // lock status
	input wire logic compat_active, // compat mode
	input wire logic cfg_compat_mode, // compat control bit
	input wire logic long_cable_active, // long cable mode
	input wire logic [3:0] adaptive_eq_gain, // eq gain
	input wire logic interrupt_out_n, // interrupt pin
	input wire logic powered_down, // power down
	input wire logic bc_line, // back channel
	input wire logic vid_valid, // pixel valid
	input wire logic vid_clk_out // output pixel clock
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ****************************************
	// assertions
	// ****************************************
	AST_PD_CLEARS: assert property (powered_down |=> !locked && interrupt_out_n && !bc_line
		&& adaptive_eq_gain == 4'h4) else $error("power down left state behind");
	AST_PD_VIDEO: assert property (powered_down |=> !vid_valid && !vid_clk_out)
		else $error("video active in power down");
	AST_COMPAT_INT: assert property (compat_active |-> interrupt_out_n)
		else $error("interrupt asserted in compat mode");
	AST_COMPAT_SRC: assert property (cfg_compat_mode && !powered_down |-> compat_active)
		else $error("control bit did not select compat mode");
	AST_LOCK_INT: assert property (locked |-> interrupt_out_n)
		else $error("interrupt low while locked");
	AST_GAIN_STEADY: assert property (locked && $past(locked) |-> $stable(adaptive_eq_gain))
		else $error("gain moved while locked");
	AST_ACQ_DEFAULT: assert property ($fell(interrupt_out_n) && !long_cable_active
		|-> adaptive_eq_gain == 4'h4) else $error("acquire not at default gain");
	AST_VID_LOCKED: assert property ($rose(vid_valid)
		|-> $past(locked) || $past(locked, 2) || $past(locked, 3)) else $error("pixel while unlocked");
	AST_VCLK_GATED: assert property (!$past(locked) |-> !vid_clk_out)
		else $error("pixel clock out while unlocked");
	// ****************************************
	// covers
	// ****************************************
	cover property ($rose(locked));
	cover property (compat_active && vid_valid);
	cover property ($fell(interrupt_out_n) && long_cable_active);
endmodule
bind svl_rx_ctrl svl_rx_ctrl_checker chk_u (.core_clk, .rst, .locked, .compat_active,
	.cfg_compat_mode, .long_cable_active, .adaptive_eq_gain, .interrupt_out_n, .powered_down,
	.bc_line, .vid_valid, .vid_clk_out);
`default_nettype wire

// file: dv/svl_serializer_model.sv
// behavioural model of the remote serializer driving the link pins
`timescale 1ns/1ns
`default_nettype none
`include "svl_regs.svh"
module svl_serializer_model (
	input wire logic run, // send symbols while high
	input wire logic drop, // send symbols marked invalid
	input wire logic [`SVL_SYM_BITS-1:0] sym_in, // payload to send
	output logic link_clk, // embedded pixel clock
	output logic link_sym_valid, // symbol framing
	output logic [`SVL_SYM_BITS-1:0] link_sym // symbol on the pair
);
	initial
	begin
		link_clk = 1'b0;
		link_sym_valid = 1'b0;
		link_sym = '0;
		// odd phase keeps link edges off the instants the bench drives
		#7;
		// clock stands still between frames, always parked low
		forever
		begin
			#200;
			if (run || link_clk)
				link_clk = ~link_clk;
		end
	end
	// change on the falling edge so the symbol is steady at the rising edge
	always @(negedge link_clk)
	begin
		link_sym_valid <= run && !drop;
		link_sym <= run ? sym_in : ~link_sym;
	end
	// a released pair drops valid at once and inverts the stale symbol
	always @(negedge run)
	begin
		link_sym_valid <= 1'b0;
		link_sym <= ~link_sym;
	end
endmodule
`default_nettype wire

// file: dv/svl_rx_ctrl_tb_top.sv
// self-checking bench for the link receiver control block
`timescale 1ns/1ns
`default_nettype none
`include "svl_regs.svh"
module svl_rx_ctrl_tb_top;
	logic core_clk, rst, power_down_n, run, drop, link_clk, link_sym_valid;
	logic mode_compat_strap, mode_long_cable_strap, cfg_compat_mode, low_freq_range_select;
	logic cfg_eq_floor_wr, cfg_cipher_key_wr, host_i2c_valid, host_i2c_ready, vid_valid;
	logic vid_ready, vid_clk_out, remote_i2c_strobe, bc_line, locked, compat_active;
	logic long_cable_active, interrupt_out_n, powered_down, host_i2c_arb_lost;
	logic [`SVL_SYM_BITS-1:0] link_sym, sym_in;
	logic [3:0] cfg_eq_floor, gpio_in, adaptive_eq_gain;
	logic [7:0] cfg_cipher_key, host_i2c_byte, remote_i2c_byte;
	svl_pkg::svl_pixel_t vid_out;
	int n_mismatch, n_checks;
	svl_serializer_model ser_u (.run, .drop, .sym_in, .link_clk, .link_sym_valid, .link_sym);
	svl_rx_ctrl dut_u (
		.core_clk, .rst, .power_down_n, .link_clk, .link_sym_valid, .link_sym, .mode_compat_strap,
		.mode_long_cable_strap, .cfg_compat_mode, .low_freq_range_select, .cfg_eq_floor,
		.cfg_eq_floor_wr, .cfg_cipher_key, .cfg_cipher_key_wr, .host_i2c_byte, .host_i2c_valid,
		.host_i2c_ready, .host_i2c_arb_lost, .gpio_in, .vid_out, .vid_valid, .vid_ready,
		.vid_clk_out, .remote_i2c_byte, .remote_i2c_strobe, .bc_line, .locked, .compat_active,
		.long_cable_active, .adaptive_eq_gain, .interrupt_out_n, .powered_down
	);
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_lock(input logic want);
		for (int i = 0; i < 400 && locked !== want; i++)
			cyc(1);
		chk("locked", want, locked);
	endtask
	// pin held low for the full minimum power-down time before release
	task automatic pd_pulse();
		power_down_n = 1'b0;
		cyc(`SVL_PD_MIN_MS * (`SVL_CLK_HZ / 1000) + 1);
		chk("powered_down", 1, powered_down);
		power_down_n = 1'b1;
		cyc(3);
		chk("gain after pd", 4'h4, adaptive_eq_gain);
		chk("locked after pd", 0, locked);
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_lock();
		int seen;
		seen = 0;
		chk("irq idle", 1, interrupt_out_n);
		run = 1'b1;
		cyc(30);
		chk("irq acquiring", 0, interrupt_out_n);
		wait_lock(1'b1);
		for (int i = 0; i < 40; i++)
		begin
			cyc(1);
			seen = seen | (vid_valid === 1'b1 ? 1 : 0) | (vid_clk_out === 1'b1 ? 2 : 0);
		end
		chk("video out", 3, seen);
	endtask
	task automatic t_fifo();
		int pops;
		pops = 0;
		vid_ready = 1'b0;
		cyc(130);
		run = 1'b0;
		cyc(20);
		vid_ready = 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			pops += (vid_valid === 1'b1);
			cyc(1);
		end
		chk("fifo depth", 8, pops);
		run = 1'b1;
	endtask
	task automatic t_miss();
		drop = 1'b1;
		cyc(8);
		drop = 1'b0;
		wait_lock(1'b0);
		wait_lock(1'b1);
	endtask
	task automatic t_backchan();
		host_i2c_byte = 8'hA5;
		host_i2c_valid = 1'b1;
		for (int i = 0; i < 200 && host_i2c_ready !== 1'b1; i++)
			cyc(1);
		cyc(1);
		host_i2c_valid = 1'b0;
		for (int i = 0; i < 200 && bc_line !== 1'b1; i++)
			cyc(1);
		for (int i = 0; i < 5; i++)
		begin
			chk("bc bit", (i == 2 || i == 3) ? 0 : 1, bc_line);
			cyc(1);
		end
		// frame in flight, so the next byte waits in the holder until dropped
		host_i2c_byte = 8'h5A;
		host_i2c_valid = 1'b1;
		cyc(1);
		host_i2c_valid = 1'b0;
		chk("ready while held", 0, host_i2c_ready);
		host_i2c_arb_lost = 1'b1;
		cyc(1);
		host_i2c_arb_lost = 1'b0;
		chk("ready after arb loss", 1, host_i2c_ready);
	endtask
	task automatic t_compat();
		int bad;
		bad = 0;
		cyc(80);
		cfg_compat_mode = 1'b1;
		low_freq_range_select = 1'b1;
		gpio_in = 4'hF;
		sym_in = '1;
		cfg_cipher_key = 8'h3C;
		cfg_cipher_key_wr = 1'b1;
		cyc(1);
		cfg_cipher_key_wr = 1'b0;
		chk("compat by bit", 1, compat_active);
		for (int i = 0; i < 150; i++)
		begin
			cyc(1);
			bad += (bc_line !== 1'b0 || interrupt_out_n !== 1'b1 || remote_i2c_strobe !== 1'b0);
		end
		chk("compat quiet", 0, bad);
		for (int i = 0; i < 40 && vid_valid !== 1'b1; i++)
			cyc(1);
		chk("compat aux", 0, {vid_out.aux_i2c, vid_out.aux_cipher, vid_out.audio});
		cfg_compat_mode = 1'b0;
	endtask
	task automatic t_straps();
		run = 1'b0;
		cyc(10);
		mode_compat_strap = 1'b1;
		mode_long_cable_strap = 1'b1;
		pd_pulse();
		chk("compat by strap", 1, compat_active);
		chk("long cable", 1, long_cable_active);
		cfg_eq_floor = 4'hA;
		cfg_eq_floor_wr = 1'b1;
		cyc(1);
		cfg_eq_floor_wr = 1'b0;
		run = 1'b1;
		cyc(30);
		chk("floor start", 4'hA, adaptive_eq_gain);
		wait_lock(1'b1);
	endtask
	task automatic t_pd_defaults();
		mode_compat_strap = 1'b0;
		mode_long_cable_strap = 1'b0;
		pd_pulse();
		chk("compat default", 0, compat_active);
		chk("long cable default", 0, long_cable_active);
	endtask
	// ****************************************
	// clock, watchdog, main sequence
	// ****************************************
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		// two full power-down holds plus the link scenarios
		#4500000;
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		{run, drop, mode_compat_strap, mode_long_cable_strap, cfg_compat_mode} = '0;
		{low_freq_range_select, cfg_eq_floor_wr, cfg_cipher_key_wr, host_i2c_valid} = '0;
		host_i2c_arb_lost = 1'b0;
		{cfg_eq_floor, gpio_in, cfg_cipher_key, host_i2c_byte} = '0;
		sym_in = 35'h5_5AA5_1234;
		power_down_n = 1'b1;
		vid_ready = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(2);
		t_lock();
		t_fifo();
		t_miss();
		t_backchan();
		t_compat();
		t_straps();
		t_pd_defaults();
		wrap_up();
	end
endmodule
`default_nettype wire
